// ==== src/dtv_pkg.sv ====
// Shared constants, types and decode functions of the tone-pair digit validator.
// Assumes a single 50 MHz clock domain; detector flags arrive from analog logic.

package dtv_pkg;

  // ****************************************************************
  // Clock and polling
  // ****************************************************************
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
  localparam int SAMPLE_US     = 1000;                       // Poll period of detector flags
  localparam int SAMPLE_CYC    = CLK_PER_US * SAMPLE_US;     // 50000 cycles

  // ****************************************************************
  // Qualification lengths, counted in poll samples
  // ****************************************************************
  localparam int TONE_QUAL_MS  = 30;     // Above 20 ms reject, below 40 ms accept
  localparam int PAUSE_QUAL_MS = 37;     // Also keeps release above 35 ms
  localparam int TONE_SAMPLES  = TONE_QUAL_MS * 1000 / SAMPLE_US;
  localparam int PAUSE_SAMPLES = PAUSE_QUAL_MS * 1000 / SAMPLE_US;
  localparam int RUN_W         = 6;

  // ****************************************************************
  // Output timing
  // ****************************************************************
  localparam int SETUP_US      = 7;                          // Code before flag, least
  localparam int SETUP_CYC     = (SETUP_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int HOLD_MIN_US   = 4200;                       // Code after flag fall, least
  localparam int HOLD_MAX_US   = 5000;                       // Code after flag fall, most
  localparam int HOLD_CYC      = HOLD_MIN_US * CLK_PER_US;   // 210000 cycles

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic       VALID_RST = 1'b0;

  // Digit codes by {row, col}; row 3 holds star, zero, hash, D
  localparam logic [63:0] CODE_TABLE = 64'h0cab_f987_e654_d321;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] low;                     // Row detectors, 697..941 Hz
    logic [3:0] high;                    // Column detectors, 1209..1633 Hz
  } dtv_tone_type;

  typedef enum logic [1:0] {
    ST_PAUSE = 2'b00,
    ST_SETUP = 2'b01,
    ST_VALID = 2'b10,
    ST_HOLD  = 2'b11
  } dtv_state_type;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic one_hot(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  function automatic logic [1:0] enc_idx(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] digit_code(input dtv_tone_type t);
    logic [3:0] idx;
    idx = {enc_idx(t.low), enc_idx(t.high)};
    return CODE_TABLE[{idx, 2'h0} +: 4];
  endfunction

endpackage

// ==== src/dtv_qualifier.sv ====
// Synchroniser, poll timer and run counters for tone pairs and pauses.
// Assumes detector flags are asynchronous levels from the analog section.
`timescale 1ns/1ps

module dtv_qualifier #(
  parameter int SAMPLE_CYC = dtv_pkg::SAMPLE_CYC
) (
  input  wire logic                  ref_clk_in,     // 50 MHz clock
  input  wire logic                  rst_b_in,       // Async reset, active low
  input  wire dtv_pkg::dtv_tone_type tone_in,        // Raw detector flags
  output logic                       tone_qual_out,  // Pulse: pair qualified
  output logic                       pause_qual_out, // Level: pause qualified
  output dtv_pkg::dtv_tone_type      pair_out        // Pair behind the run
);

  localparam int TW    = $clog2(SAMPLE_CYC);
  localparam int RUN_W = dtv_pkg::RUN_W;

  dtv_pkg::dtv_tone_type  meta_q;
  dtv_pkg::dtv_tone_type  sync_q;
  logic [TW-1:0]          tick_cnt_q;
  logic                   tick_q;
  logic [dtv_pkg::RUN_W-1:0] tone_run_q;
  logic [dtv_pkg::RUN_W-1:0] pause_run_q;
  logic                   pair_ok;

  // ****************************************************************
  // Two-stage synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= tone_in;
      sync_q <= meta_q;
    end
  end

  // Poll tick from the local clock; both run lengths hang off it
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TW'(SAMPLE_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == TW'(SAMPLE_CYC - 1)) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Exactly one flag per group makes a candidate pair
  assign pair_ok = dtv_pkg::one_hot(sync_q.low) && dtv_pkg::one_hot(sync_q.high);

  // Consecutive identical samples build the run; any change restarts it
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tone_run_q    <= '0;
      pair_out      <= '0;
      tone_qual_out <= 1'b0;
    end else begin
      tone_qual_out <= 1'b0;
      if (tick_q) begin
        pair_out <= sync_q;
        if (pair_ok && sync_q == pair_out && tone_run_q != '0) begin
          if (tone_run_q != RUN_W'(dtv_pkg::TONE_SAMPLES)) begin
            tone_run_q <= tone_run_q + 1'b1;
          end
          tone_qual_out <= (tone_run_q == RUN_W'(dtv_pkg::TONE_SAMPLES - 1));
        end else begin
          tone_run_q <= pair_ok ? RUN_W'(1) : '0;
        end
      end
    end
  end

  // Pause is timed as samples with no valid pair
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pause_run_q    <= '0;
      pause_qual_out <= 1'b0;
    end else if (tick_q) begin
      if (pair_ok) begin
        pause_run_q    <= '0;
        pause_qual_out <= 1'b0;
      end else begin
        if (pause_run_q != RUN_W'(dtv_pkg::PAUSE_SAMPLES)) begin
          pause_run_q <= pause_run_q + 1'b1;
        end
        pause_qual_out <= (pause_run_q >= RUN_W'(dtv_pkg::PAUSE_SAMPLES - 1));
      end
    end
  end

endmodule // dtv_qualifier

// ==== src/dtv_digit_validator.sv ====
// Top of the tone-pair digit validator: output state machine and pins.
// Assumes detector flags and enable come from outside the clock domain.
`timescale 1ns/1ps

module dtv_digit_validator #(
  parameter int SAMPLE_CYC = dtv_pkg::SAMPLE_CYC,
  parameter int HOLD_CYC   = dtv_pkg::HOLD_CYC
) (
  input  wire logic                  ref_clk_in,      // 50 MHz clock
  input  wire logic                  rst_b_in,        // Async reset, active low
  input  wire dtv_pkg::dtv_tone_type tone_flags_in,   // Detector flags, async
  input  wire logic                  out_en_in,       // Reader's output enable, async
  output logic [3:0]                 code_out,        // Code bits 3..0
  output logic                       code_oe_out,     // Code pins driven when high
  output logic                       digit_valid_out  // Digit valid flag
);

  // Timer serves setup and hold, so it must fit the longer of the two
  localparam int TMAX = (HOLD_CYC > dtv_pkg::SETUP_CYC) ? HOLD_CYC : dtv_pkg::SETUP_CYC;
  localparam int TW   = $clog2(TMAX + 1);

  logic                   tone_qual;
  logic                   pause_qual;
  dtv_pkg::dtv_tone_type  pair;
  dtv_pkg::dtv_state_type state_q;
  logic [TW-1:0]          timer_q;
  logic                   en_meta_q;
  logic                   accept;

  // ****************************************************************
  // Sampling and qualification
  // ****************************************************************
  dtv_qualifier #(
    .SAMPLE_CYC (SAMPLE_CYC)
  ) u_qual (
    .ref_clk_in     (ref_clk_in),
    .rst_b_in       (rst_b_in),
    .tone_in        (tone_flags_in),
    .tone_qual_out  (tone_qual),
    .pause_qual_out (pause_qual),
    .pair_out       (pair)
  );

  // New digit only from pause or hold, both past a valid pause or a reset
  assign accept = tone_qual && (state_q == dtv_pkg::ST_PAUSE || state_q == dtv_pkg::ST_HOLD);

  // ****************************************************************
  // Digit state machine
  // ****************************************************************
  // Reset lands in pause so a first digit needs full qualification
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= dtv_pkg::ST_PAUSE;
      timer_q <= '0;
    end else begin
      unique case (state_q)
        dtv_pkg::ST_PAUSE: begin
          timer_q <= '0;
          if (accept) begin
            state_q <= dtv_pkg::ST_SETUP;
          end
        end
        dtv_pkg::ST_SETUP: begin
          // Hold the flag back until the code has stood its setup time
          if (timer_q == TW'(dtv_pkg::SETUP_CYC - 1)) begin
            timer_q <= '0;
            state_q <= dtv_pkg::ST_VALID;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        dtv_pkg::ST_VALID: begin
          timer_q <= '0;
          if (pause_qual) begin
            state_q <= dtv_pkg::ST_HOLD;
          end
        end
        dtv_pkg::ST_HOLD: begin
          if (accept) begin
            timer_q <= '0;
            state_q <= dtv_pkg::ST_SETUP;
          end else if (timer_q == TW'(HOLD_CYC - 1)) begin
            timer_q <= '0;
            state_q <= dtv_pkg::ST_PAUSE;
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Code bits
  // ****************************************************************
  // Loaded on acceptance, cleared when the hold after the pause runs out
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_out <= dtv_pkg::CODE_RST;
    end else if (accept) begin
      code_out <= dtv_pkg::digit_code(pair);
    end else if (state_q == dtv_pkg::ST_HOLD && timer_q == TW'(HOLD_CYC - 1)) begin
      code_out <= dtv_pkg::CODE_RST;
    end
  end

  // Flag follows the valid state; transitions only from setup and on pause
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      digit_valid_out <= dtv_pkg::VALID_RST;
    end else if (state_q == dtv_pkg::ST_SETUP && timer_q == TW'(dtv_pkg::SETUP_CYC - 1)) begin
      digit_valid_out <= 1'b1;
    end else if (state_q == dtv_pkg::ST_VALID && pause_qual) begin
      digit_valid_out <= 1'b0;
    end
  end

  // Enable is a pin; two flops before it steers the drivers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_meta_q   <= 1'b0;
      code_oe_out <= 1'b0;
    end else begin
      en_meta_q   <= out_en_in;
      code_oe_out <= en_meta_q;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic [TW-1:0] code_age_q;   // Cycles since code last changed
  logic [TW-1:0] fall_age_q;   // Cycles since flag fell

  // Helper ages for the setup and hold checks
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_age_q <= '0;
      fall_age_q <= '0;
    end else begin
      if (code_out != $past(code_out)) begin
        code_age_q <= '0;
      end else if (code_age_q != TW'(TMAX)) begin
        code_age_q <= code_age_q + 1'b1;
      end
      if (digit_valid_out) begin
        fall_age_q <= '0;
      end else if (fall_age_q != TW'(HOLD_CYC)) begin
        fall_age_q <= fall_age_q + 1'b1;
      end
    end
  end

  sequence s_enter_setup;
    accept ##1 (state_q == dtv_pkg::ST_SETUP);
  endsequence

  sequence s_setup_quiet;
    (state_q == dtv_pkg::ST_SETUP && !digit_valid_out)[*8];
  endsequence

  a_setup_then_flag: assert property (s_enter_setup |-> s_setup_quiet)
    else $error("flag rose early in setup");
  // Age restarts one edge after the change, so a full setup shows one less
  a_setup_time: assert property ($rose(digit_valid_out)
                                 |-> code_age_q >= TW'(dtv_pkg::SETUP_CYC - 1))
    else $error("code not stable long enough before flag");
  a_flag_from_setup: assert property ($rose(digit_valid_out) |-> $past(state_q) == dtv_pkg::ST_SETUP)
    else $error("flag rose outside setup");
  a_flag_held: assert property ($fell(digit_valid_out) |-> $past(pause_qual))
    else $error("flag fell without a pause");
  a_no_retrigger: assert property (state_q == dtv_pkg::ST_VALID && tone_qual && !pause_qual
                                   |=> state_q == dtv_pkg::ST_VALID && $stable(code_out))
    else $error("digit reported without pause");
  a_code_hold: assert property ($changed(code_out) && $past(state_q) == dtv_pkg::ST_HOLD
                                && !$past(accept) && code_out == dtv_pkg::CODE_RST
                                |-> fall_age_q == TW'(HOLD_CYC))
    else $error("code cleared at wrong time after flag fall");
  a_pause_clear: assert property (state_q == dtv_pkg::ST_PAUSE |-> code_out == dtv_pkg::CODE_RST
                                  && !digit_valid_out)
    else $error("pause state with code or flag set");
  a_code_map: assert property (accept |=> code_out == dtv_pkg::digit_code($past(pair)))
    else $error("wrong digit code loaded");
  a_pair_onehot: assert property (accept |-> dtv_pkg::one_hot(pair.low)
                                  && dtv_pkg::one_hot(pair.high))
    else $error("accepted pair not one per group");
  // Skip the two edges after reset while the synchroniser refills
  a_enable_follow: assert property ($past(rst_b_in, 2)
                                    |-> code_oe_out == $past(out_en_in, 2))
    else $error("output enable not following input");
  a_valid_flag: assert property (state_q == dtv_pkg::ST_VALID |-> digit_valid_out)
    else $error("flag low in valid state");

endmodule // dtv_digit_validator

// ==== verif/dtv_reader_model.sv ====
// Reader model: a processor port that samples the three-state code bus.
// Assumes the bench asks for the enable; the model resolves the code wire.
`timescale 1ns/1ps

module dtv_reader_model (
  input  wire logic       clk_in,     // Bus clock
  input  wire logic [3:0] code_in,    // Code pins of the device
  input  wire logic       code_oe_in, // Device drives the pins when high
  input  wire logic       flag_in,    // Digit valid flag
  input  wire logic       en_req_in,  // Bench asks for the enable
  output logic            out_en_out, // Output enable to the device
  output wire logic [3:0] bus_out,    // Resolved code wire
  output logic [3:0]      digit_out,  // Last digit taken
  output logic [7:0]      rises_out   // Digits counted
);
  logic flag_q;

  // Nothing else drives the wire, so it floats while the pins are off
  assign bus_out = code_oe_in ? code_in : 4'bzzzz;

  initial begin
    out_en_out = 1'b0;
    flag_q     = 1'b0;
    digit_out  = 4'h0;
    rises_out  = 8'h0;
  end

  // Enable moves off the sampling edge only
  always @(negedge clk_in) begin
    out_en_out <= en_req_in;
  end

  // Each flag rise is one new digit, taken from the wire itself
  always @(posedge clk_in) begin
    flag_q <= flag_in;
    if (flag_in === 1'b1 && flag_q !== 1'b1) begin
      digit_out <= bus_out;
      rises_out <= rises_out + 8'h1;
    end
  end
endmodule // dtv_reader_model

// ==== verif/dtv_digit_validator_tb.sv ====
// Self-checking bench of the tone-pair digit validator with a bus reader.
// Assumes a shortened poll period; one scaled millisecond is SC cycles.
`timescale 1ns/1ps

module dtv_digit_validator_tb;
  localparam int SC    = 50;     // Cycles per poll, one scaled ms
  localparam int HC    = 100;    // Shortened code hold
  localparam int LIMIT = 95000;  // Whole run should end well before
  localparam logic [3:0] EXP [16] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
                                      4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};

  logic                  ref_clk;
  logic                  rst_b;
  dtv_pkg::dtv_tone_type tone;
  logic                  out_en;
  logic                  en_req;
  logic [3:0]            code;
  logic                  code_oe;
  logic                  flag;
  wire  [3:0]            bus;
  logic [3:0]            digit;
  logic [7:0]            rises;
  int                    errors;
  int                    num_checks;
  int                    cycles;

  dtv_digit_validator #(.SAMPLE_CYC(SC), .HOLD_CYC(HC)) uut (
    .ref_clk_in(ref_clk), .rst_b_in(rst_b), .tone_flags_in(tone), .out_en_in(out_en),
    .code_out(code), .code_oe_out(code_oe), .digit_valid_out(flag));

  dtv_reader_model reader (
    .clk_in(ref_clk), .code_in(code), .code_oe_in(code_oe), .flag_in(flag),
    .en_req_in(en_req), .out_en_out(out_en), .bus_out(bus), .digit_out(digit),
    .rises_out(rises));

  // ****************************************************************
  // Clock and watchdog
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // A hung wait counts as a mismatch and ends the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Negative row or column means silence on that group
  task automatic set_pair(input int r, input int c);
    @(negedge ref_clk);
    tone.low  = (r < 0) ? 4'h0 : 4'(1 << r);
    tone.high = (c < 0) ? 4'h0 : 4'(1 << c);
  endtask

  // Counts the cycles in which the flag differs from the level wanted
  task automatic watch(input int ms, input logic want, inout int bad);
    repeat (ms * SC) begin
      @(negedge ref_clk);
      if (flag !== want) bad++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check("flag after reset", flag, 1'b0);
    check("code after reset", code, 4'h0);
    check("reader digits", rises, 8'h0);
    $display("reset test done");
  endtask

  // One 41 ms digit: latencies, setup, code, wire and hold
  task automatic run_digit(input int r, input int c);
    int n;
    int stable;
    logic [3:0] last;
    n = 0;
    stable = 0;
    last = code;
    set_pair(r, c);
    while (flag !== 1'b1 && n < 60 * SC) begin
      @(negedge ref_clk);
      n++;
      stable = (code === last) ? stable + 1 : 0;
      last = code;
    end
    check("detect latency in window", n >= 25 * SC && n <= 46 * SC, 1'b1);
    check("code setup before flag", stable >= dtv_pkg::SETUP_CYC, 1'b1);
    check("code at flag rise", code, EXP[r * 4 + c]);
    @(negedge ref_clk);
    check("code on enabled wire", bus, EXP[r * 4 + c]);
    check("digit taken by reader", digit, EXP[r * 4 + c]);
    repeat (41 * SC - n - 2) @(negedge ref_clk);
    set_pair(-1, -1);
    n = 0;
    while (flag !== 1'b0 && n < 60 * SC) begin
      @(negedge ref_clk);
      n++;
    end
    check("release latency in window", n >= 35 * SC && n <= 50 * SC, 1'b1);
    check("code kept at flag fall", code, EXP[r * 4 + c]);
    // A zero code cannot show its clear, so only its presence is judged
    if (EXP[r * 4 + c] == 4'h0) begin
      repeat (HC) @(negedge ref_clk);
      check("zero code through hold", code, 4'h0);
    end else begin
      n = 0;
      while (code !== 4'h0 && n < 2 * HC) begin
        @(negedge ref_clk);
        n++;
      end
      check("code hold interval", n >= HC && n <= HC * 50 / 42, 1'b1);
    end
  endtask

  task automatic t_all_digits();
    for (int i = 0; i < 16; i++) begin
      run_digit(i / 4, i % 4);
    end
    check("digits counted", rises, 8'd16);
    $display("digit table test done");
  endtask

  // Short, invalid and inconsistent tones never make a digit
  task automatic t_rejects();
    int bad;
    bad = 0;
    set_pair(0, 0);
    watch(20, 1'b0, bad);
    set_pair(-1, -1);
    watch(30, 1'b0, bad);
    check("short tone refused", bad, 0);
    @(negedge ref_clk);
    tone.low  = 4'h3;
    tone.high = 4'h1;
    watch(41, 1'b0, bad);
    set_pair(-1, -1);
    watch(5, 1'b0, bad);
    check("two rows refused", bad, 0);
    set_pair(1, 1);
    watch(25, 1'b0, bad);
    set_pair(2, 2);
    watch(25, 1'b0, bad);
    set_pair(-1, -1);
    watch(10, 1'b0, bad);
    check("changed pair restarts", bad, 0);
    $display("reject test done");
  endtask

  // A short gap is no pause: flag holds and no second digit appears
  task automatic t_no_pause();
    int bad;
    logic [7:0] base;
    bad = 0;
    base = rises;
    set_pair(0, 1);
    watch(41, 1'b0, bad);
    check("flag up after first tone", flag, 1'b1);
    en_req = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("wire floats when disabled", bus, 4'bzzzz);
    en_req = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("wire driven again", bus, EXP[1]);
    bad = 0;
    set_pair(-1, -1);
    watch(15, 1'b1, bad);
    check("short gap keeps flag", bad, 0);
    set_pair(1, 2);
    watch(41, 1'b1, bad);
    check("flag held without pause", bad, 0);
    check("no second digit", rises, base + 8'h1);
    check("code of first digit kept", code, EXP[1]);
    set_pair(-1, -1);
    watch(50, 1'b0, bad);
    check("pause releases flag", bad >= 35 * SC && bad < 50 * SC, 1'b1);
    repeat (2 * HC) @(negedge ref_clk);
    check("code cleared after pause", code, 4'h0);
    $display("no pause test done");
  endtask

  // Reset in mid digit drops flag and code; the tone must qualify afresh
  task automatic t_mid_reset();
    int bad;
    bad = 0;
    set_pair(2, 1);
    watch(41, 1'b0, bad);
    check("flag up before reset", flag, 1'b1);
    rst_b = 1'b0;
    @(negedge ref_clk);
    check("flag in reset", flag, 1'b0);
    check("code in reset", code, 4'h0);
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    bad = 0;
    watch(25, 1'b0, bad);
    set_pair(-1, -1);
    watch(45, 1'b0, bad);
    check("no digit without full run", bad, 0);
    check("code clear after reset", code, 4'h0);
    $display("mid reset test done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    errors = 0;
    num_checks = 0;
    cycles = 0;
    tone = '0;
    en_req = 1'b1;
    rst_b = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_all_digits();
    t_rejects();
    t_no_pause();
    t_mid_reset();
    report_and_stop();
  end
endmodule // dtv_digit_validator_tb
